// File: design/nsx_pkg.sv
// package for the nibble swap and pointer subtract execution block
package nsx_pkg;
	localparam int unsigned NSX_DATA_W = 8;
	localparam int unsigned NSX_PTR_W = 12;
	localparam int unsigned NSX_ADDR_W = 12;
	// opcode prefixes
	localparam logic [5:0] NSX_SWAP_PREFIX = 6'h0e;
	localparam logic [7:0] NSX_SUBP_PREFIX = 8'he9;
	localparam logic [1:0] NSX_SUBP_NO_PTR = 2'h3;
	localparam int unsigned NSX_LIT_W = 6;
	// encoding field positions
	localparam int unsigned NSX_D_BIT = 9;
	localparam int unsigned NSX_A_BIT = 8;
	// indexed literal offset limit and access bank split
	localparam logic [7:0] NSX_IDX_MAX = 8'h5f;
	localparam logic [7:0] NSX_ACC_SPLIT = 8'h80;
	localparam logic [3:0] NSX_SFR_BANK = 4'hf;
	localparam logic [3:0] NSX_ACC_BANK = 4'h0;
	localparam logic [1:0] NSX_IDX_PTR = 2'h2;
	localparam logic [1:0] NSX_PTR_CNT = 2'h3;

	typedef enum logic [1:0] {
		NSX_Q1,
		NSX_Q2,
		NSX_Q3,
		NSX_Q4
	} nsx_phase_t;

	// file register write request
	typedef struct packed {
		logic en;
		logic [NSX_ADDR_W-1:0] addr;
		logic [NSX_DATA_W-1:0] data;
	} nsx_fwr_t;
endpackage : nsx_pkg

// File: design/nsx_exec.sv
// execution core for nibble swap and pointer literal subtract
//
// Functional notes
// - nibble_swap_op exchanges upper and lower nibbles
// - d=0 writes working register, d=1 file
// - a=0 access bank, a=1 bank_select_reg bank
// - extended set, a=0, f<=95: indexed literal offset
// - subtract 6-bit literal from selected indirect_pointer_reg
module nsx_exec
	import nsx_pkg::*;
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_reset,
	// instruction stream, one word per instruction cycle
	input wire logic [15:0] i_instr,
	input wire logic i_ext_set_en,
	input wire logic [3:0] i_bank_select_reg,
	// file operand read data
	input wire logic [NSX_DATA_W-1:0] i_file_rdata,
	// file access
	output logic [NSX_ADDR_W-1:0] o_file_addr,
	output logic o_file_rd,
	output nsx_fwr_t o_file_wr,
	// architectural state
	output logic [NSX_DATA_W-1:0] o_wreg,
	output logic [NSX_PTR_W-1:0] o_ptr0,
	output logic [NSX_PTR_W-1:0] o_ptr1,
	output logic [NSX_PTR_W-1:0] o_ptr2,
	output logic [4:0] o_status,
	output nsx_phase_t o_phase
);

	////////////////////////////////////////////////////////////////////////////
	// decode helpers

	function automatic logic is_swap(input logic [15:0] w);
		return w[15:10] == NSX_SWAP_PREFIX;
	endfunction

	function automatic logic is_subp(input logic [15:0] w);
		return (w[15:8] == NSX_SUBP_PREFIX) && (w[7:6] != NSX_SUBP_NO_PTR);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// phase counter and latched instruction

	nsx_phase_t phase_q;
	logic [15:0] ir_q;
	logic [NSX_DATA_W-1:0] opnd_q;
	logic [NSX_DATA_W-1:0] res_q;
	logic [NSX_PTR_W-1:0] ptr_q [3];
	logic [NSX_PTR_W-1:0] pres_q;
	logic [NSX_ADDR_W-1:0] addr_d;

	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
			phase_q <= NSX_Q1;
		else
			case (phase_q)
				NSX_Q1: phase_q <= NSX_Q2;
				NSX_Q2: phase_q <= NSX_Q3;
				NSX_Q3: phase_q <= NSX_Q4;
				default: phase_q <= NSX_Q1;
			endcase
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
			ir_q <= 16'h0000;
		else if (phase_q == NSX_Q1)
			ir_q <= i_instr;
	end

	////////////////////////////////////////////////////////////////////////////
	// file address resolution

	always_comb
	begin
		if (!ir_q[NSX_A_BIT] && i_ext_set_en && ir_q[7:0] <= NSX_IDX_MAX)
			addr_d = ptr_q[NSX_IDX_PTR] + {4'h0, ir_q[7:0]};
		else if (!ir_q[NSX_A_BIT])
			addr_d = {(ir_q[7:0] >= NSX_ACC_SPLIT) ? NSX_SFR_BANK : NSX_ACC_BANK,
				ir_q[7:0]};
		else
			addr_d = {i_bank_select_reg, ir_q[7:0]};
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
		begin
			o_file_addr <= 12'h000;
			o_file_rd <= 1'b0;
		end
		else
		begin
			o_file_addr <= addr_d;
			o_file_rd <= (phase_q == NSX_Q1) ? 1'b0 : (phase_q == NSX_Q2) && is_swap(ir_q);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read, process

	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
			opnd_q <= 8'h00;
		else if (phase_q == NSX_Q2)
			opnd_q <= i_file_rdata;
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
			res_q <= 8'h00;
		else if (phase_q == NSX_Q3)
			res_q <= {opnd_q[3:0], opnd_q[7:4]};
	end

	// only a valid pointer field indexes the array; field 3 would read past its end
	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
			pres_q <= 12'h000;
		else if (phase_q == NSX_Q3 && is_subp(ir_q))
			pres_q <= ptr_q[ir_q[7:6]] - {6'h00, ir_q[5:0]};
	end

	////////////////////////////////////////////////////////////////////////////
	// write destination

	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
			o_wreg <= 8'h00;
		else if (phase_q == NSX_Q4 && is_swap(ir_q) && !ir_q[NSX_D_BIT])
			o_wreg <= res_q;
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
			o_file_wr <= '0;
		else
		begin
			o_file_wr.en <= (phase_q == NSX_Q4) && is_swap(ir_q) && ir_q[NSX_D_BIT];
			o_file_wr.addr <= addr_d;
			o_file_wr.data <= res_q;
		end
	end

	for (genvar gi = 0; gi < NSX_PTR_CNT; gi++)
	begin : g_ptr
		always_ff @(posedge i_clk_sys)
		begin
			if (i_reset)
				ptr_q[gi] <= 12'h000;
			else if (phase_q == NSX_Q4 && is_subp(ir_q) && ir_q[7:6] == 2'(gi))
				ptr_q[gi] <= pres_q;
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
			o_status <= 5'h00;
		else
			o_status <= o_status;
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_reset)
			o_phase <= NSX_Q1;
		else
			o_phase <= phase_q;
	end

	assign o_ptr0 = ptr_q[0];
	assign o_ptr1 = ptr_q[1];
	assign o_ptr2 = ptr_q[2];

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);

	a_phase_order: assert property (phase_q == NSX_Q1 |=> phase_q == NSX_Q2)
		else $error("phase order broken");
	a_cycle_len: assert property (phase_q == NSX_Q4 |=> phase_q == NSX_Q1 ##4 phase_q == NSX_Q1)
		else $error("instruction cycle not four phases");
	a_swap_wreg: assert property (phase_q == NSX_Q4 && is_swap(ir_q) && !ir_q[NSX_D_BIT]
		|=> o_wreg == {$past(opnd_q[3:0]), $past(opnd_q[7:4])})
		else $error("swap to working register wrong");
	a_swap_file: assert property (phase_q == NSX_Q4 && is_swap(ir_q) && ir_q[NSX_D_BIT]
		|=> o_file_wr.en && o_file_wr.data == {$past(opnd_q[3:0]), $past(opnd_q[7:4])})
		else $error("swap to file wrong");
	a_wreg_hold: assert property (phase_q == NSX_Q4 && !(is_swap(ir_q) && !ir_q[NSX_D_BIT])
		|=> $stable(o_wreg))
		else $error("working register changed");
	a_bank_sel: assert property (ir_q[NSX_A_BIT] |-> addr_d == {i_bank_select_reg, ir_q[7:0]})
		else $error("bank select not used");
	a_idx_addr: assert property (!ir_q[NSX_A_BIT] && i_ext_set_en && ir_q[7:0] <= NSX_IDX_MAX
		|-> addr_d == ptr_q[NSX_IDX_PTR] + {4'h0, ir_q[7:0]})
		else $error("indexed offset address wrong");
	a_ptr_sub: assert property (phase_q == NSX_Q4 && is_subp(ir_q)
		|=> ptr_q[$past(ir_q[7:6])]
			== $past(ptr_q[ir_q[7:6]]) - {6'h00, $past(ir_q[5:0])})
		else $error("pointer subtract wrong");
	a_status_keep: assert property ($stable(o_status))
		else $error("status flags changed");

	c_swap_w: cover property (phase_q == NSX_Q4 && is_swap(ir_q) && !ir_q[NSX_D_BIT]);
	c_swap_f: cover property (phase_q == NSX_Q4 && is_swap(ir_q) && ir_q[NSX_D_BIT]);
	c_subp: cover property (phase_q == NSX_Q4 && is_subp(ir_q));
	c_idx: cover property (phase_q == NSX_Q2 && is_swap(ir_q) && !ir_q[NSX_A_BIT] && i_ext_set_en);

endmodule // nsx_exec

// File: testbench/tb_top.sv
// self-checking bench for the nibble swap and pointer subtract block
module tb_top
	import nsx_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic i_clk_sys;
	logic i_reset;
	logic [15:0] i_instr;
	logic i_ext_set_en;
	logic [3:0] i_bank_select_reg;
	logic [7:0] i_file_rdata;
	logic [11:0] o_file_addr;
	logic o_file_rd;
	nsx_fwr_t o_file_wr;
	logic [7:0] o_wreg;
	logic [11:0] o_ptr0;
	logic [11:0] o_ptr1;
	logic [11:0] o_ptr2;
	logic [4:0] o_status;
	nsx_phase_t o_phase;
	int fail_count;
	int compares;
	int cycles;
	logic [11:0] exp_ptr [3];

	nsx_exec DUT (
		.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_instr(i_instr),
		.i_ext_set_en(i_ext_set_en), .i_bank_select_reg(i_bank_select_reg),
		.i_file_rdata(i_file_rdata), .o_file_addr(o_file_addr), .o_file_rd(o_file_rd),
		.o_file_wr(o_file_wr), .o_wreg(o_wreg), .o_ptr0(o_ptr0), .o_ptr1(o_ptr1),
		.o_ptr2(o_ptr2), .o_status(o_status), .o_phase(o_phase)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		if (fail_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// word driven one edge before the Q1 edge that latches it, an idle word after it; judged mid-cycle
	task automatic exec(input logic [15:0] w, input logic [7:0] r, input logic exp_rd);
		logic rd;
		do
			@(posedge i_clk_sys);
		while (o_phase != NSX_Q3);
		i_instr <= w;
		i_file_rdata <= r;
		repeat (2) @(posedge i_clk_sys);
		@(negedge i_clk_sys);
		rd = o_file_rd;
		repeat (2) @(posedge i_clk_sys);
		i_instr <= 16'h0000;
		@(negedge i_clk_sys);
		check(rd, exp_rd);
		check(o_phase, NSX_Q4);
		check(o_status, 5'h00);
	endtask

	task automatic swap_op(input logic d, input logic a, input logic [7:0] f,
		input logic [7:0] r, input logic [11:0] adr);
		logic [7:0] res;
		res = {r[3:0], r[7:4]};
		exec({NSX_SWAP_PREFIX, d, a, f}, r, 1'b1);
		check(o_file_addr, adr);
		if (d)
			check(o_file_wr, {1'b1, adr, res});
		else
			check({o_file_wr.en, o_wreg}, {1'b0, res});
	endtask

	task automatic sub_op(input logic [1:0] p, input logic [5:0] k);
		if (p != NSX_SUBP_NO_PTR)
			exp_ptr[p] = exp_ptr[p] - {6'h00, k};
		exec({NSX_SUBP_PREFIX, p, k}, 8'hff, 1'b0);
		check({o_ptr0, o_ptr1, o_ptr2}, {exp_ptr[0], exp_ptr[1], exp_ptr[2]});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		exec(16'h0000, 8'h5a, 1'b0);
		check({o_wreg, o_ptr0, o_ptr1, o_ptr2, o_file_wr.en}, 40'h0);
	endtask

	task automatic t_ptr;
		for (int i = 0; i < 4; i++)
		begin
			sub_op(i[1:0], 6'h3f);
			sub_op(i[1:0], 6'h23);
		end
	endtask

	task automatic t_swap_dest;
		@(posedge i_clk_sys);
		i_bank_select_reg <= 4'h5;
		swap_op(1'b0, 1'b1, 8'h2c, 8'h53, 12'h52c);
		swap_op(1'b1, 1'b1, 8'h2c, 8'ha7, 12'h52c);
		check(o_wreg, 8'h35);
	endtask

	task automatic t_bank;
		swap_op(1'b1, 1'b0, 8'h9a, 8'h3c, 12'hf9a);
		swap_op(1'b1, 1'b0, 8'h20, 8'h6d, 12'h020);
		swap_op(1'b1, 1'b0, 8'h7f, 8'hc1, 12'h07f);
		swap_op(1'b1, 1'b1, 8'h7f, 8'h0f, 12'h57f);
	endtask

	task automatic t_indexed;
		@(posedge i_clk_sys);
		i_ext_set_en <= 1'b1;
		swap_op(1'b1, 1'b0, 8'h5f, 8'h12, exp_ptr[2] + 12'h05f);
		swap_op(1'b1, 1'b0, 8'h60, 8'he4, 12'h060);
		swap_op(1'b1, 1'b1, 8'h10, 8'h9b, 12'h510);
		swap_op(1'b0, 1'b0, 8'h00, 8'h81, exp_ptr[2]);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		i_clk_sys = 1'b0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end

	always @(posedge i_clk_sys)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			fail_count++;
			end_of_test;
		end
	end

	initial
	begin
		i_reset = 1'b1;
		i_instr = 16'h0000;
		i_ext_set_en = 1'b0;
		i_bank_select_reg = 4'h0;
		i_file_rdata = 8'h00;
		foreach (exp_ptr[i])
			exp_ptr[i] = 12'h000;
		repeat (2) @(posedge i_clk_sys);
		i_reset <= 1'b0;
		t_reset;
		t_ptr;
		t_swap_dest;
		t_bank;
		t_indexed;
		end_of_test;
	end
endmodule // tb_top
